// ---- verilog/dsem_pkg.sv ----
// constants and types for the semaphore token requester
package dsem_pkg;
   localparam int           DSEM_CELL_BITS   = 3;
   localparam int           DSEM_DATA_BITS   = 8;
   localparam int           DSEM_CELLS       = 8;
   localparam logic         DSEM_REQ_VAL     = 1'b0;
   localparam logic         DSEM_REL_VAL     = 1'b1;
   localparam int           DSEM_CLK_MHZ     = 200;
   // strobe width and recovery between accesses, ns
   localparam int           DSEM_STROBE_NS   = 50;
   localparam int           DSEM_GAP_NS      = 20;
   localparam int           DSEM_STROBE_CYC  = (DSEM_STROBE_NS * DSEM_CLK_MHZ + 999) / 1000;
   localparam int           DSEM_GAP_CYC     = (DSEM_GAP_NS * DSEM_CLK_MHZ + 999) / 1000;
   localparam int           DSEM_CNT_BITS    = 8;

   typedef enum logic [2:0]
   {
      DSEM_IDLE  = 3'b000,
      DSEM_WRITE = 3'b001,
      DSEM_READ  = 3'b010,
      DSEM_GAP   = 3'b011,
      DSEM_HOLD  = 3'b100
   } dsem_state_type;

   typedef enum logic [1:0]
   {
      DSEM_OP_NONE    = 2'b00,
      DSEM_OP_ACQUIRE = 2'b01,
      DSEM_OP_RELEASE = 2'b10
   } dsem_op_type;
endpackage : dsem_pkg

// ---- verilog/dsem_timer.sv ----
// down counter that pulses done when a loaded count runs out
`timescale 1ns/1ps
module dsem_timer #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   // status
   output logic              done
);
   logic [W-1:0] cnt_q;
   logic         run_q;

   // count down; done is high for one cycle at expiry
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end
      else if (load)
      begin
         cnt_q <= count;
         run_q <= 1'b1;
      end
      else if (run_q)
      begin
         cnt_q <= cnt_q - 1'b1;
         if (cnt_q == W'(1))
            run_q <= 1'b0;
      end
   end

   assign done = run_q && (cnt_q == W'(1));
endmodule : dsem_timer

// ---- verilog/dsem_host.sv ----
// requester that takes and frees one semaphore token over the device pins
`timescale 1ns/1ps
module dsem_host
   import dsem_pkg::*;
#(
   parameter int STROBE_CYC = dsem_pkg::DSEM_STROBE_CYC,
   parameter int GAP_CYC    = dsem_pkg::DSEM_GAP_CYC
) (
   // clock and reset
   input  wire logic                                clock,
   input  wire logic                                rst,
   // user command port
   input  wire logic                                cmd_valid,
   output logic                                     cmd_ready,
   input  wire dsem_pkg::dsem_op_type               cmd_op,
   input  wire logic [dsem_pkg::DSEM_CELL_BITS-1:0] cmd_cell,
   output logic                                     granted,
   output logic                                     done_pulse,
   output logic [dsem_pkg::DSEM_CELL_BITS-1:0]      held_cell,
   // device semaphore pins
   output logic                                     token_cell_select_n,
   output logic                                     write_n,
   output logic                                     output_enable_n,
   output logic [dsem_pkg::DSEM_CELL_BITS-1:0]      addr,
   output logic                                     token_data_bit_out,
   output logic                                     token_data_bit_oe,
   input  wire logic [dsem_pkg::DSEM_DATA_BITS-1:0] data_in
);
   import dsem_pkg::*;

   dsem_state_type                state_q, state_d;
   logic                          rel_q;
   logic [DSEM_CELL_BITS-1:0]     cell_q;
   logic                          granted_q;
   logic                          done_q;
   logic [DSEM_DATA_BITS-1:0]     sync1_q, sync2_q;
   logic                          tmr_load;
   logic [DSEM_CNT_BITS-1:0]      tmr_count;
   logic                          tmr_done;
   logic                          take_cmd;
   logic                          rd_zero;

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchroniser; data pins come from another domain
   always_ff @(posedge clock)
   begin
      sync1_q <= data_in;
      sync2_q <= sync1_q;
   end

   // all lines carry the token bit; any zero line would be a glitch, so all must agree
   // no copy of the token is kept here: every poll goes out to the pins
   assign rd_zero = (sync2_q == '0);

   ////////////////////////////////////////////////////////////////////////////
   // command acceptance
   assign cmd_ready = (state_q == DSEM_IDLE) || (state_q == DSEM_HOLD);
   assign take_cmd  = cmd_valid && cmd_ready &&
                      ((state_q == DSEM_IDLE) ? (cmd_op == DSEM_OP_ACQUIRE)
                                              : (cmd_op == DSEM_OP_RELEASE));

   // the timer paces strobe width and recovery; it reloads at the end of every
   // phase except the two that finish a command, so a stale zero seen while the
   // bus is idle can never stall the next read
   // limitation: STROBE_CYC must be 3 or more, since the read is sampled two flops late
   assign tmr_load  = take_cmd ||
                      (tmr_done && !(state_q == DSEM_WRITE && rel_q) &&
                       !(state_q == DSEM_READ && rd_zero));
   assign tmr_count = (state_q == DSEM_WRITE && !rel_q) || (state_q == DSEM_READ)
                      ? DSEM_CNT_BITS'(GAP_CYC) : DSEM_CNT_BITS'(STROBE_CYC);

   dsem_timer #(
      .W     (DSEM_CNT_BITS)
   ) u_timer (
      .clock (clock),
      .rst   (rst),
      .load  (tmr_load),
      .count (tmr_count),
      .done  (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: write, then for an acquire poll with cyclic reads until zero; a release returns to idle
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         DSEM_IDLE : if (take_cmd) state_d = DSEM_WRITE;
         DSEM_WRITE: if (tmr_done) state_d = rel_q ? DSEM_IDLE : DSEM_GAP;
         DSEM_GAP  : if (tmr_done) state_d = DSEM_READ;
         // read strobe drops between polls so the device hold latch refreshes
         DSEM_READ : if (tmr_done) state_d = rd_zero ? DSEM_HOLD : DSEM_GAP;
         DSEM_HOLD : if (take_cmd) state_d = DSEM_WRITE;
         default   : state_d = DSEM_IDLE;
      endcase
   end

   // sequencer and user state registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q   <= DSEM_IDLE;
         rel_q     <= 1'b0;
         cell_q    <= '0;
         granted_q <= 1'b0;
         done_q    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         done_q  <= 1'b0;
         if (take_cmd)
         begin
            rel_q <= (cmd_op == DSEM_OP_RELEASE);
            if (state_q == DSEM_IDLE)
               cell_q <= cmd_cell;
         end
         if (state_q == DSEM_READ && tmr_done && rd_zero)
         begin
            granted_q <= 1'b1;
            done_q    <= 1'b1;
         end
         if (state_q == DSEM_WRITE && tmr_done && rel_q)
         begin
            granted_q <= 1'b0;
            done_q    <= 1'b1;
         end
      end
   end

   assign granted    = granted_q;
   assign done_pulse = done_q;
   assign held_cell  = cell_q;

   ////////////////////////////////////////////////////////////////////////////
   // device pins; strobe decodes are named wires
   wire in_write = (state_q == DSEM_WRITE);
   wire in_read  = (state_q == DSEM_READ);

   assign token_cell_select_n = !(in_write || in_read);
   assign write_n             = !in_write;
   assign output_enable_n     = !in_read;
   assign addr                = cell_q;
   assign token_data_bit_oe   = in_write;
   assign token_data_bit_out  = rel_q ? DSEM_REL_VAL : DSEM_REQ_VAL;
endmodule : dsem_host

// ---- test/dsem_host_checker.sv ----
// pin-level assertions for the token requester
`timescale 1ns/1ps
module dsem_host_checker (
   // clock, reset and status
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       granted,
   input wire logic       done_pulse,
   input wire logic [2:0] held_cell,
   // device pins
   input wire logic       token_cell_select_n,
   input wire logic       write_n,
   input wire logic       output_enable_n,
   input wire logic [2:0] addr,
   input wire logic       token_data_bit_out,
   input wire logic       token_data_bit_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire wr = !token_cell_select_n && !write_n;
   // a write asks for the token unless held, then it frees it
   property p_req; wr && !granted |-> token_data_bit_oe && !token_data_bit_out; endproperty
   a_req: assert property (p_req) else $error("request write not zero");
   property p_rel; wr && granted |-> token_data_bit_oe && token_data_bit_out; endproperty
   a_rel: assert property (p_rel) else $error("release write not one");
   property p_rd; !output_enable_n |-> write_n && !token_data_bit_oe; endproperty
   a_rd: assert property (p_rd) else $error("read overlaps a write");
   property p_cell; !token_cell_select_n |-> write_n != output_enable_n; endproperty
   a_cell: assert property (p_cell) else $error("select without one strobe");
   property p_hold; granted && $past(granted) |-> $stable(held_cell) && !done_pulse; endproperty
   a_hold: assert property (p_hold) else $error("holding not steady");
   property p_done; $changed(granted) |-> done_pulse ##1 !done_pulse; endproperty
   a_done: assert property (p_done) else $error("no single done");
   c_grant: cover property ($rose(granted));
   c_free: cover property ($fell(granted));
   c_poll: cover property (!output_enable_n && !granted);
endmodule : dsem_host_checker
bind dsem_host dsem_host_checker u_chk (.*);

// ---- test/dsem_device_model.sv ----
// eight token cells with an opposite port that the bench drives
`timescale 1ns/1ps
module dsem_device_model (
   // host pins
   input wire logic       clock,
   input wire logic       sel_n,
   input wire logic       we_n,
   input wire logic       oe_n,
   input wire logic [2:0] addr,
   input wire logic       din,
   output logic     [7:0] dout,
   // opposite port
   input wire logic       o_we,
   input wire logic [2:0] o_cell,
   input wire logic       o_val
);
   int         own [8]; // 0 free, 1 host, 2 opposite
   bit         pend [8]; // zero left waiting by the non-holder
   logic [7:0] last = 8'h00;
   // zero takes or waits; one frees and hands to the waiter
   task automatic put(input int c, input int w, input logic v);
      if (!v && own[c] == 0)
         own[c] = w;
      else if (!v && own[c] != w)
         pend[c] = 1;
      else if (v && own[c] == w)
      begin
         own[c] = pend[c] ? 3 - w : 0;
         pend[c] = 0;
      end
   endtask : put
   // host applied first, so a tie goes to one side only
   always @(posedge clock)
   begin
      if (!sel_n && !we_n)
         put(addr, 1, din);
      if (o_we)
         put(o_cell, 2, o_val);
      last <= dout;
   end
   // all lines repeat the cell; an idle bus toggles
   assign dout = (!sel_n && !oe_n) ? {8{own[addr] != 1}} : ~last;
endmodule : dsem_device_model

// ---- test/tb_dual_port_semaphore_token.sv ----
// self-checking bench for the token requester
`timescale 1ns/1ps
module tb_dual_port_semaphore_token;
   import dsem_pkg::*;
   logic        clock = 0, rst = 1, cmd_valid = 0, o_we = 0, o_val = 1, ok;
   logic [2:0]  cmd_cell = 0, o_cell = 0, c;
   logic [31:0] seed = 3878;
   dsem_op_type cmd_op = DSEM_OP_NONE;
   wire         cmd_ready, granted, done_pulse, sel_n, we_n, oe_n, d_out, d_oe;
   wire [2:0]   held_cell, addr;
   wire [7:0]   data;
   int          err_total = 0, checks_done = 0, far_has = 0;
   always #2.5 clock = ~clock;
   dsem_host #(.STROBE_CYC(4), .GAP_CYC(2)) uut (.clock(clock), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_cell(cmd_cell),
      .granted(granted), .done_pulse(done_pulse), .held_cell(held_cell),
      .token_cell_select_n(sel_n), .write_n(we_n), .output_enable_n(oe_n), .addr(addr),
      .token_data_bit_out(d_out), .token_data_bit_oe(d_oe), .data_in(data));
   dsem_device_model dev (.clock(clock), .sel_n(sel_n), .we_n(we_n), .oe_n(oe_n),
      .addr(addr), .din(d_oe ? d_out : 1'b1), .dout(data), .o_we(o_we), .o_cell(o_cell),
      .o_val(o_val));
   function logic [2:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[2:0];
   endfunction : xs
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s: expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   task complete_run;
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task wdone(input int lim);
      ok = 0;
      for (int n = 0; n < lim && !ok; n++) @(posedge clock) #1 ok = done_pulse === 1'b1;
   endtask : wdone
   task act(input dsem_op_type o, input logic [2:0] cc, input int lim);
      @(posedge clock) #1 {cmd_valid, cmd_op, cmd_cell} = {1'b1, o, cc};
      while (cmd_ready !== 1'b1) @(posedge clock) #1;
      @(posedge clock) #1 cmd_valid = 0;
      wdone(lim);
   endtask : act
   task far(input logic [2:0] cc, input logic v);
      @(posedge clock) #1 {o_we, o_cell, o_val} = {1'b1, cc, v};
      @(posedge clock) #1 o_we = 0;
   endtask : far
   // eight pseudo-random cells, then a refused op and a contended cell both ways
   initial
   begin
      repeat (6) @(posedge clock);
      #1 rst = 0;
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i) ^ xs();
         act(DSEM_OP_ACQUIRE, c, 60);
         chk("grant", 8'(far_has == 0), 8'(ok));
         chk("cell", 8'(c), 8'(held_cell));
         act(DSEM_OP_RELEASE, c, 60);
         chk("held", 8'h00, 8'(granted));
      end
      act(DSEM_OP_RELEASE, c, 20);
      chk("idle release", 8'h00, 8'(ok));
      far(c, 0);
      far_has = 1;
      act(DSEM_OP_ACQUIRE, c, 60);
      chk("denied", 8'(far_has == 0), 8'(ok));
      far(c, 1);
      wdone(60);
      chk("late grant", 8'h01, 8'(ok));
      far(c, 0);
      act(DSEM_OP_RELEASE, c, 60);
      chk("released", 8'h00, 8'(granted));
      act(DSEM_OP_ACQUIRE, c, 40);
      chk("denied", 8'(far_has == 0), 8'(ok));
      far(c, 1);
      wdone(60);
      chk("second late grant", 8'h01, 8'(ok));
      act(DSEM_OP_RELEASE, c, 60);
      chk("final", 8'h00, 8'(granted));
      complete_run();
   end
   initial
   begin
      #100000;
      err_total++;
      complete_run();
   end
endmodule : tb_dual_port_semaphore_token
